/* hdl/l1_data_cache.sv */
// l1_data_cache: first level data cache, two load ports, one store port
// assumes: next level answers each request with four 16-byte beats in
// chunk order; core offers stores to the store port only after retire
`timescale 1ns/1ps
module l1_data_cache #(
    parameter int LDB = l1d_pkg::LDB_ENTRIES,
    parameter int STB = l1d_pkg::STB_ENTRIES,
    parameter int MFB = l1d_pkg::MFB_ENTRIES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // load ports
    input wire logic [1:0] ldValid,
    input wire logic [1:0] ldWide,
    input wire logic [1:0][l1d_pkg::ADDR_W-1:0] ldAddr,
    output logic [1:0] ldReady,
    output logic [1:0] ldRespValid,
    output logic [1:0][l1d_pkg::CHUNK_W-1:0] ldRespData,
    // buffer tracking
    input wire logic ldAlloc,
    input wire logic ldRetire,
    output logic ldBufFull,
    input wire logic stAlloc,
    output logic stBufFull,
    // retired stores
    input wire logic stValid,
    input wire logic [l1d_pkg::ADDR_W-1:0] stAddr,
    input wire logic [l1d_pkg::CHUNK_W-1:0] stData,
    input wire logic [l1d_pkg::CHUNK_BYTES-1:0] stMask,
    output logic stCommit,
    // next level requests
    output logic reqValid,
    input wire logic reqReady,
    output logic [l1d_pkg::LINE_W-1:0] reqAddr,
    output logic reqOwn,
    output logic [l1d_pkg::MFB_ID_W-1:0] reqId,
    // next level fills
    input wire logic fillValid,
    input wire logic [l1d_pkg::MFB_ID_W-1:0] fillId,
    input wire logic fillExcl,
    input wire logic [l1d_pkg::CHUNK_W-1:0] fillData,
    // victim write-back
    output logic wbValid,
    output logic [l1d_pkg::CADDR_W-1:0] wbAddr,
    output logic [l1d_pkg::CHUNK_W-1:0] wbData
);
    import l1d_pkg::*;

    localparam int LCW = $clog2(LDB + 1);
    localparam int SCW = $clog2(STB + 1);
    localparam int SQW = $clog2(STB);
    localparam int SQ_W = CADDR_W + CHUNK_W + CHUNK_BYTES;

    if (MFB < 1 || MFB > 2**MFB_ID_W || STB < 2 || LDB < 1) begin : g_chk
        $error("l1_data_cache: buffer depth out of range");
    end

    typedef struct packed {
        logic [SETS-1:0][WAYS-1:0][TAG_W-1:0] tag;
        mesi_t [SETS-1:0][WAYS-1:0] mesi;
        logic [SETS-1:0][WAY_W-1:0] rr;
        logic [1:0] rdy, hold, hw, s1v, s2v, s3v, rv;
        logic [1:0][ADDR_W-1:0] ha;
        logic [1:0][DA_W-1:0] s1ra;
        logic [1:0][CHUNK_W-1:0] s3d, rd;
        logic [LCW-1:0] ldCnt;
        logic ldFull;
        logic [SCW-1:0] stCnt, sqRet;
        logic stFull, stDone;
        logic [SQW-1:0] sqHead, sqTail;
        sc_t sc;
        logic [CADDR_W-1:0] scA;
        logic [CHUNK_W-1:0] scD;
        logic [CHUNK_BYTES-1:0] scM;
        logic [MFB-1:0] mv, mi, mo;
        logic [MFB-1:0][LINE_W-1:0] ml;
        logic qv, qo;
        logic [LINE_W-1:0] qa;
        logic [MFB_ID_W-1:0] qi;
        logic [CHK_W-1:0] fbeat;
        logic [SET_W-1:0] fset;
        logic [WAY_W-1:0] fway;
        logic fvm, wbv;
        logic [TAG_W-1:0] vtag;
        logic [CADDR_W-1:0] wba;
    } st_t;

    st_t s, n;

    function automatic logic [SET_W-1:0] setOf(input logic [ADDR_W-1:0] a);
        return a[OFF_W +: SET_W];
    endfunction

    function automatic logic [TAG_W-1:0] tagOf(input logic [ADDR_W-1:0] a);
        return a[OFF_W+SET_W +: TAG_W];
    endfunction

    // {hit, way}
    function automatic logic [WAY_W:0] lookup(input st_t x,
                                              input logic [ADDR_W-1:0] a);
        logic [WAY_W:0] r;
        r = '0;
        for (int w = 0; w < WAYS; w++) begin
            if (x.mesi[setOf(a)][w] != INV
                && x.tag[setOf(a)][w] == tagOf(a)) begin
                r = {1'b1, WAY_W'(w)};
            end
        end
        return r;
    endfunction

    // same line first (upgrade), then a free way, then round robin
    function automatic logic [WAY_W-1:0] victim(input st_t x,
                                                input logic [SET_W-1:0] st,
                                                input logic [TAG_W-1:0] tg);
        logic [WAY_W-1:0] v;
        logic f;
        v = x.rr[st];
        f = 1'b0;
        for (int w = 0; w < WAYS; w++) begin
            if (!f && x.mesi[st][w] == INV) begin
                v = WAY_W'(w);
                f = 1'b1;
            end
        end
        for (int w = 0; w < WAYS; w++) begin
            if (x.mesi[st][w] != INV && x.tag[st][w] == tg) begin
                v = WAY_W'(w);
            end
        end
        return v;
    endfunction

    function automatic logic [SQW-1:0] qinc(input logic [SQW-1:0] x);
        return (x == SQW'(STB - 1)) ? '0 : x + 1'b1;
    endfunction

    logic [1:0] srcV, srcW, srv, blk;
    logic [1:0][ADDR_W-1:0] srcA;
    logic [1:0][WAY_W:0] lk;
    logic [WAY_W:0] lks;
    logic [ADDR_W-1:0] scAddr;
    logic conflict, fillAct, stWr, pop, vmNow;
    logic [2:0] want, ok;
    logic [2:0][LINE_W-1:0] wl;
    logic [SET_W-1:0] fsNow;
    logic [WAY_W-1:0] fwNow;
    logic [TAG_W-1:0] ftNow;
    logic [CHUNK_BYTES-1:0] dWe;
    logic [DA_W-1:0] dWa;
    logic [CHUNK_W-1:0] dWd;
    logic [2:0][DA_W-1:0] dRa;
    logic [2:0][CHUNK_W-1:0] dRd;
    logic [0:0][SQ_W-1:0] sqRd;

    always_comb begin
        n = s;
        n.stDone = 1'b0;
        n.wbv = 1'b0;
        want = '0;
        ok = '0;
        wl = '0;
        stWr = 1'b0;
        pop = 1'b0;
        vmNow = 1'b0;
        dWe = '0;
        dWa = '0;
        dWd = fillData;
        dRa = {DA_W'(0), s.s1ra[1], s.s1ra[0]};
        // answer pipe: lookup, array read, stage, answer
        n.s2v = s.s1v;
        n.s3v = s.s2v;
        n.rv = s.s3v;
        n.s3d = {dRd[1], dRd[0]};
        n.rd = s.s3d;
        // fill in progress blocks its own set
        fillAct = fillValid || s.fbeat != '0;
        fsNow = (s.fbeat != '0) ? s.fset : s.ml[fillId][SET_W-1:0];
        ftNow = s.ml[fillId][SET_W +: TAG_W];
        fwNow = (s.fbeat != '0) ? s.fway : victim(s, fsNow, ftNow);
        for (int p = 0; p < 2; p++) begin
            srcV[p] = s.hold[p] || (ldValid[p] && s.rdy[p]);
            srcA[p] = s.hold[p] ? s.ha[p] : ldAddr[p];
            srcW[p] = s.hold[p] ? s.hw[p] : ldWide[p];
            lk[p] = lookup(s, srcA[p]);
            blk[p] = fillAct && setOf(srcA[p]) == fsNow;
        end
        // both 16-byte halves use the same two banks
        conflict = srcV[0] && srcV[1]
            && srcA[0][CHK_LSB +: CHK_W] == srcA[1][CHK_LSB +: CHK_W]
            && srcA[0][ADDR_W-1:OFF_W] != srcA[1][ADDR_W-1:OFF_W];
        for (int p = 0; p < 2; p++) begin
            // loads served as they come; misses stall the other port only when a port 0 miss, held or new, bank-conflicts with a port 1 load
            srv[p] = srcV[p] && lk[p][WAY_W] && !blk[p]
                && !(p == 1 && conflict);
            n.s1v[p] = srv[p];
            n.s1ra[p] = {setOf(srcA[p]), lk[p][WAY_W-1:0],
                         srcA[p][CHK_LSB +: CHK_W]};
            if (srv[p]) begin
                // second half of a wide load follows as its own access
                n.hold[p] = srcW[p];
                n.ha[p] = srcA[p] + ADDR_W'(CHUNK_BYTES);
                n.hw[p] = 1'b0;
            end else if (srcV[p]) begin
                n.hold[p] = 1'b1;
                n.ha[p] = srcA[p];
                n.hw[p] = srcW[p];
            end
            want[p] = srcV[p] && !lk[p][WAY_W] && !blk[p];
            wl[p] = srcA[p][ADDR_W-1:OFF_W];
            n.rdy[p] = !n.hold[p];
        end
        // fill beats own the write port; the victim is read first
        if (fillValid) begin
            if (s.fbeat == '0) begin
                n.fset = fsNow;
                n.fway = fwNow;
                n.fvm = s.mesi[fsNow][fwNow] == MOD;
                n.vtag = s.tag[fsNow][fwNow];
                n.tag[fsNow][fwNow] = ftNow;
                n.mesi[fsNow][fwNow] = INV;
                n.rr[fsNow] = fwNow + 1'b1;
            end
            vmNow = (s.fbeat == '0) ? s.mesi[fsNow][fwNow] == MOD : s.fvm;
            dWe = '1;
            dWa = {fsNow, fwNow, s.fbeat};
            dRa[2] = dWa;
            n.wbv = vmNow;
            n.wba = {(s.fbeat == '0) ? s.tag[fsNow][fwNow] : s.vtag,
                     fsNow, s.fbeat};
            n.fbeat = s.fbeat + 1'b1;
            if (s.fbeat == CHK_W'(3)) begin
                // lower level grants shared only when peers may hold it
                n.mesi[fsNow][fwNow] =
                    (s.mo[fillId] || fillExcl) ? EXC : SHR;
                n.mv[fillId] = 1'b0;
                n.mi[fillId] = 1'b0;
            end
        end
        // store commit, strictly one at a time from the head
        scAddr = {s.scA, CHK_LSB'(0)};
        lks = lookup(s, scAddr);
        case (s.sc)
            SC_IDLE: begin
                if (s.sqRet != '0) begin
                    n.sc = SC_READ;
                end
            end
            SC_READ: begin
                n.scA = sqRd[0][SQ_W-1 -: CADDR_W];
                n.scD = sqRd[0][CHUNK_BYTES +: CHUNK_W];
                n.scM = sqRd[0][CHUNK_BYTES-1:0];
                n.sc = SC_LOOK;
            end
            SC_LOOK: begin
                // a fill beat owns the write port, whatever its set
                if (!fillValid && !(fillAct && setOf(scAddr) == fsNow)) begin
                    if (lks[WAY_W]
                        && s.mesi[setOf(scAddr)][lks[WAY_W-1:0]] >= EXC) begin
                        // hit stays local, nothing goes below
                        stWr = 1'b1;
                        n.mesi[setOf(scAddr)][lks[WAY_W-1:0]] = MOD;
                        pop = 1'b1;
                        n.stDone = 1'b1;
                        n.sc = SC_IDLE;
                    end else begin
                        want[2] = 1'b1;
                        wl[2] = scAddr[ADDR_W-1:OFF_W];
                    end
                end
            end
            SC_WAIT: begin
                n.sc = SC_LOOK;
                for (int e = 0; e < MFB; e++) begin
                    if (s.mv[e] && s.ml[e] == scAddr[ADDR_W-1:OFF_W]) begin
                        n.sc = SC_WAIT;
                    end
                end
            end
            default: n.sc = SC_IDLE;
        endcase
        if (stWr) begin
            dWe = s.scM;
            dWa = {setOf(scAddr), lks[WAY_W-1:0], s.scA[CHK_W-1:0]};
            dWd = s.scD;
        end
        // miss tracking: merge on the same line, else take a free entry
        for (int r = 0; r < 3; r++) begin
            if (want[r]) begin
                for (int e = 0; e < MFB; e++) begin
                    if (n.mv[e] && n.ml[e] == wl[r]) begin
                        ok[r] = 1'b1;
                    end
                end
                for (int e = 0; e < MFB; e++) begin
                    if (!ok[r] && !n.mv[e]) begin
                        n.mv[e] = 1'b1;
                        n.mi[e] = 1'b0;
                        n.mo[e] = r == 2;
                        n.ml[e] = wl[r];
                        ok[r] = 1'b1;
                    end
                end
            end
        end
        if (ok[2]) begin
            n.sc = SC_WAIT;
        end
        // one request line to the next level, lowest entry first;
        // the lower levels do the search down to memory
        if (s.qv && reqReady) begin
            n.qv = 1'b0;
        end
        for (int e = 0; e < MFB; e++) begin
            if (!n.qv && n.mv[e] && !n.mi[e]) begin
                n.qv = 1'b1;
                n.qa = n.ml[e];
                n.qo = n.mo[e];
                n.qi = MFB_ID_W'(e);
                n.mi[e] = 1'b1;
            end
        end
        // buffer occupancy
        if (stValid) begin
            n.sqTail = qinc(s.sqTail);
        end
        if (pop) begin
            n.sqHead = qinc(s.sqHead);
        end
        n.sqRet = s.sqRet + SCW'(stValid) - SCW'(pop);
        n.stCnt = s.stCnt + SCW'(stAlloc) - SCW'(pop);
        n.stFull = n.stCnt == SCW'(STB);
        n.ldCnt = s.ldCnt + LCW'(ldAlloc) - LCW'(ldRetire);
        n.ldFull = n.ldCnt == LCW'(LDB);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    lane_ram #(.W(CHUNK_W), .D(2**DA_W), .NRD(3), .LANES(CHUNK_BYTES))
    u_data (
        .clk(mclk),
        .we(dWe),
        .wa(dWa),
        .wd(dWd),
        .ra(dRa),
        .rd(dRd)
    );

    lane_ram #(.W(SQ_W), .D(STB), .NRD(1), .LANES(1)) u_stq (
        .clk(mclk),
        .we(stValid),
        .wa(s.sqTail),
        .wd({stAddr[ADDR_W-1:CHK_LSB], stData, stMask}),
        .ra(s.sqHead),
        .rd(sqRd)
    );

    assign ldReady = s.rdy;
    assign ldRespValid = s.rv;
    assign ldRespData = s.rd;
    assign ldBufFull = s.ldFull;
    assign stBufFull = s.stFull;
    assign stCommit = s.stDone;
    assign reqValid = s.qv;
    assign reqAddr = s.qa;
    assign reqOwn = s.qo;
    assign reqId = s.qi;
    assign wbValid = s.wbv;
    assign wbAddr = s.wba;
    assign wbData = dRd[2]; // the array's own output register

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    hit_latency_a:
    assert property (srv[0] |-> ##4 ldRespValid[0])
        else $error("load hit answer not four cycles later");
    miss_overlap_a:
    assert property (s.mv != '0 && srv[1] |-> ##4 ldRespValid[1])
        else $error("hit stalled behind pending misses");
    bank_retry_a:
    assert property (conflict && srv[0] && lk[1][WAY_W] && !blk[1]
                     |=> s.hold[1] && !ldReady[1])
        else $error("bank conflict not held on port 1");
    wide_split_a:
    assert property (srv[0] && srcW[0] |=> s.hold[0]
                     && s.ha[0] == $past(srcA[0]) + 32'h10)
        else $error("wide load second half missing");
    store_owned_a:
    assert property (stWr |-> lks[WAY_W]
                     && s.mesi[setOf(scAddr)][lks[WAY_W-1:0]] inside {EXC, MOD})
        else $error("store written without ownership");
    store_mod_a:
    assert property (stWr |=> stCommit
        && s.mesi[setOf($past(scAddr))][$past(lks[WAY_W-1:0])] == MOD)
        else $error("stored line not modified");
    commit_order_a:
    assert property (stCommit |-> s.sqHead == qinc($past(s.sqHead)))
        else $error("store commit out of order");
    victim_wb_a:
    assert property (fillValid && vmNow
                     |=> wbValid && wbAddr[CHK_W-1:0] == $past(s.fbeat))
        else $error("modified victim not written back with fill");
    store_full_a:
    assert property (stCommit && !$past(stAlloc) |-> !stBufFull)
        else $error("store buffer full flag wrong");
    load_full_a:
    assert property (ldAlloc && !ldRetire && !ldBufFull
                     |=> s.ldCnt == $past(s.ldCnt) + 1'b1)
        else $error("load tracking count not advanced");
endmodule

/* include/l1d_pkg.sv */
// l1d_pkg: constants and types of the first level data cache
// assumes: compiled before every design file that imports it
package l1d_pkg;
    // geometry
    localparam int ADDR_W = 32;
    localparam int CACHE_BYTES = 32768;
    localparam int WAYS = 8;
    localparam int LINE_BYTES = 64;
    localparam int BANKS = 8;
    localparam int CHUNK_BYTES = 16;
    localparam int CHUNK_W = CHUNK_BYTES * 8;
    localparam int SETS = CACHE_BYTES / (WAYS * LINE_BYTES);
    localparam int OFF_W = $clog2(LINE_BYTES);
    localparam int CHK_LSB = $clog2(CHUNK_BYTES);
    localparam int CHK_W = OFF_W - CHK_LSB;
    localparam int SET_W = $clog2(SETS);
    localparam int WAY_W = $clog2(WAYS);
    localparam int TAG_W = ADDR_W - OFF_W - SET_W;
    localparam int LINE_W = ADDR_W - OFF_W;
    localparam int CADDR_W = ADDR_W - CHK_LSB;
    localparam int DA_W = SET_W + WAY_W + CHK_W;
    // tracking depths
    localparam int LDB_ENTRIES = 64;
    localparam int STB_ENTRIES = 36;
    localparam int MFB_ENTRIES = 10;
    localparam int MFB_ID_W = 4;
    // best case load latency, core cycles
    localparam int L1_HIT_CYCLES = 4;
    localparam int L2_HIT_CYCLES = 12;
    localparam int LLC_HIT_MIN = 26;
    localparam int LLC_HIT_MAX = 31;
    localparam int PEER_CLEAN_CYCLES = 43;
    localparam int PEER_DIRTY_CYCLES = 60;
    // second level and lower transfer width
    localparam int L2_BYTES = 262144;
    localparam int L2_WAYS = 8;
    localparam int LOWER_BEAT_BYTES = 32;
    // line coherence state
    typedef enum logic [1:0] {
        INV = 2'h0,
        SHR = 2'h1,
        EXC = 2'h2,
        MOD = 2'h3
    } mesi_t;
    // store commit sequencer, gray along idle-read-look-wait
    typedef enum logic [1:0] {
        SC_IDLE = 2'h0,
        SC_READ = 2'h1,
        SC_LOOK = 2'h3,
        SC_WAIT = 2'h2
    } sc_t;
endpackage

/* hdl/lane_ram.sv */
// lane_ram: write-one read-many memory with byte lanes
// assumes: one clock; read data registered, old data on a same-cycle write
`timescale 1ns/1ps
module lane_ram #(
    parameter int W = 128,
    parameter int D = 2048,
    parameter int NRD = 1,
    parameter int LANES = 1
) (
    // clock
    input wire logic clk,
    // write side
    input wire logic [LANES-1:0] we,
    input wire logic [$clog2(D)-1:0] wa,
    input wire logic [W-1:0] wd,
    // read side
    input wire logic [NRD-1:0][$clog2(D)-1:0] ra,
    output logic [NRD-1:0][W-1:0] rd
);
    localparam int LW = W / LANES;
    logic [W-1:0] mem [D];

    if (W % LANES != 0 || NRD < 1) begin : g_chk
        $error("lane_ram: width must split into whole lanes");
    end

    always_ff @(posedge clk) begin
        for (int r = 0; r < NRD; r++) begin
            rd[r] <= mem[ra[r]];
        end
        for (int l = 0; l < LANES; l++) begin
            if (we[l]) begin
                mem[wa][l*LW +: LW] <= wd[l*LW +: LW];
            end
        end
    end
endmodule

/* verification/next_level_model.sv */
// next_level_model: behavioural second level behind the data cache
// assumes: one request at a time; a beat carries its chunk address x4
`timescale 1ns/1ps
module next_level_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // requests
    input wire logic reqValid,
    output logic reqReady,
    input wire logic [l1d_pkg::LINE_W-1:0] reqAddr,
    input wire logic reqOwn,
    input wire logic [l1d_pkg::MFB_ID_W-1:0] reqId,
    // fills
    output logic fillValid,
    output logic [l1d_pkg::MFB_ID_W-1:0] fillId,
    output logic fillExcl,
    output logic [l1d_pkg::CHUNK_W-1:0] fillData,
    // bench controls
    input wire logic grantExcl,
    input wire logic [7:0] delay
);
    import l1d_pkg::*;
    int reqCount;
    logic [LINE_W-1:0] lastAddr;
    logic lastOwn;
    logic [MFB_ID_W-1:0] id;
    initial begin
        reqReady = 1'b0;
        fillValid = 1'b0;
        fillId = '0;
        fillExcl = 1'b0;
        fillData = '0;
        reqCount = 0;
        wait (rst === 1'b0);
        forever begin
            @(posedge mclk);
            #1;
            reqReady = 1'b1;
            while (reqValid !== 1'b1) begin
                @(posedge mclk);
                #1;
            end
            lastAddr = reqAddr;
            lastOwn = reqOwn;
            id = reqId;
            @(posedge mclk);
            #1;
            reqReady = 1'b0;
            reqCount++;
            if (delay != 0) begin
                repeat (delay) @(posedge mclk);
                #1;
            end
            // serial fills never interleave
            for (int c = 0; c < 4; c++) begin
                fillValid = 1'b1;
                fillId = id;
                fillExcl = lastOwn | grantExcl;
                fillData = {4{lastAddr, c[1:0], 4'h0}};
                @(posedge mclk);
                #1;
            end
            // released bus must not look like a stale beat
            fillValid = 1'b0;
            fillData = ~fillData;
        end
    end
endmodule

/* verification/l1_data_cache_hierarchy_bench.sv */
// l1_data_cache_hierarchy_bench: self-checking bench of the data cache
// assumes: next_level_model answers misses; one 200 MHz clock
`timescale 1ns/1ps
module l1_data_cache_hierarchy_bench;
    import l1d_pkg::*;
    `define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin \
        err_count++; $display("mismatch %s exp %0h got %0h", nm, e, s); \
        end end
    logic mclk, rst, ldAlloc, ldRetire, ldBufFull, stAlloc, stBufFull;
    logic [1:0] ldValid, ldWide, ldReady, ldRespValid;
    logic [1:0][ADDR_W-1:0] ldAddr;
    logic [1:0][CHUNK_W-1:0] ldRespData;
    logic stValid, stCommit, reqValid, reqReady, reqOwn, fillValid;
    logic fillExcl, wbValid, grantExcl;
    logic [ADDR_W-1:0] stAddr;
    logic [CHUNK_W-1:0] stData, fillData, wbData;
    logic [CHUNK_BYTES-1:0] stMask;
    logic [LINE_W-1:0] reqAddr;
    logic [MFB_ID_W-1:0] reqId, fillId;
    logic [CADDR_W-1:0] wbAddr;
    logic [7:0] delay;
    int err_count, compares, cyc, wbCnt, rc;
    localparam logic [31:0] A = 32'h0000_1040;
    localparam logic [31:0] B = 32'h0000_2040;
    localparam logic [31:0] C = 32'h0000_3080;
    localparam logic [127:0] D = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
    l1_data_cache dut_u (.mclk(mclk), .rst(rst), .ldValid(ldValid),
        .ldWide(ldWide), .ldAddr(ldAddr), .ldReady(ldReady),
        .ldRespValid(ldRespValid), .ldRespData(ldRespData),
        .ldAlloc(ldAlloc), .ldRetire(ldRetire), .ldBufFull(ldBufFull),
        .stAlloc(stAlloc), .stBufFull(stBufFull), .stValid(stValid),
        .stAddr(stAddr), .stData(stData), .stMask(stMask),
        .stCommit(stCommit), .reqValid(reqValid), .reqReady(reqReady),
        .reqAddr(reqAddr), .reqOwn(reqOwn), .reqId(reqId),
        .fillValid(fillValid), .fillId(fillId), .fillExcl(fillExcl),
        .fillData(fillData), .wbValid(wbValid), .wbAddr(wbAddr),
        .wbData(wbData));
    next_level_model mdl_u (.mclk(mclk), .rst(rst), .reqValid(reqValid),
        .reqReady(reqReady), .reqAddr(reqAddr), .reqOwn(reqOwn),
        .reqId(reqId), .fillValid(fillValid), .fillId(fillId),
        .fillExcl(fillExcl), .fillData(fillData), .grantExcl(grantExcl),
        .delay(delay));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end
    // sampled mid-cycle, away from the launching edge
    always @(negedge mclk) begin
        if (wbValid === 1'b1) begin
            `CHK("wb set", 6'h00, wbAddr[7:2])
            `CHK("wb data", mrg(pat(32'h1000 + 32'(wbCnt * 16)), D,
                wbCnt == 0 ? 16'h000f : 16'h0000), wbData)
            wbCnt++;
        end
    end
    function automatic logic [127:0] pat(input logic [31:0] a);
        return {4{a[31:4], 4'h0}};
    endfunction
    function automatic logic [127:0] mrg(input logic [127:0] o, n,
            input logic [15:0] m);
        for (int i = 0; i < 16; i++)
            if (m[i]) o[i*8+:8] = n[i*8+:8];
        return o;
    endfunction
    task automatic step();
        @(posedge mclk);
        #1;
    endtask
    task automatic finish_test();
        if (err_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // lat 0: miss, no latency figure
    task automatic load(input int p, input logic [31:0] a, input bit wide,
            input int lat, input logic [127:0] e);
        int n;
        ldValid[p] = 1'b1;
        ldWide[p] = wide;
        ldAddr[p] = a;
        while (ldReady[p] !== 1'b1) step();
        step();
        ldValid[p] = 1'b0;
        n = 1;
        while (ldRespValid[p] !== 1'b1 && n < 400) begin
            step();
            n++;
        end
        `CHK("load data", e, ldRespData[p])
        if (lat != 0) `CHK("load latency", lat, n)
        if (wide) begin
            step();
            while (ldRespValid[p] !== 1'b1 && n < 400) begin
                step();
                n++;
            end
            `CHK("upper half", pat(a + 32'h10), ldRespData[p])
        end
    endtask
    task automatic pair(input logic [31:0] a0, a1, input int lat1);
        int n;
        logic [1:0] seen;
        ldValid = 2'b11;
        ldWide = 2'b00;
        ldAddr[0] = a0;
        ldAddr[1] = a1;
        while (ldReady !== 2'b11) step();
        step();
        ldValid = 2'b00;
        seen = 2'b00;
        n = 1;
        while (seen != 2'b11 && n < 60) begin
            for (int p = 0; p < 2; p++)
                if (ldRespValid[p] === 1'b1) begin
                    seen[p] = 1'b1;
                    `CHK("pair data", pat(p ? a1 : a0), ldRespData[p])
                    if (p == 0 || lat1 != 0) `CHK("pair lat", 4, n)
                    else `CHK("replayed", 1'b1, n > 4)
                end
            step();
            n++;
        end
        `CHK("pair done", 2'b11, seen)
    endtask
    task automatic store(input logic [31:0] a, input logic [127:0] d,
            input logic [15:0] m, input int lat, input bit al);
        int n;
        stValid = 1'b1;
        stAlloc = al;
        stAddr = a;
        stData = d;
        stMask = m;
        step();
        stValid = 1'b0;
        stAlloc = 1'b0;
        n = 1;
        while (stCommit !== 1'b1 && n < 400) begin
            step();
            n++;
        end
        `CHK("commit", 1'b1, stCommit)
        if (lat != 0) `CHK("commit lat", lat, n)
    endtask
    initial begin
        rst = 1'b1;
        ldValid = '0;
        ldWide = '0;
        ldAddr = '0;
        ldAlloc = 1'b0;
        ldRetire = 1'b0;
        stAlloc = 1'b0;
        stValid = 1'b0;
        stAddr = '0;
        stData = '0;
        stMask = '0;
        grantExcl = 1'b1;
        delay = 8'h00;
        repeat (16) step();
        `CHK("ready in reset", 2'b00, ldReady)
        rst = 1'b0;
        step();
        `CHK("ready", 2'b11, ldReady)
        // miss, then wide hit on the other port
        load(0, A, 0, 0, pat(A));
        `CHK("req line", A[31:6], mdl_u.lastAddr)
        `CHK("req own", 1'b0, mdl_u.lastOwn)
        load(1, A + 32'h20, 1, 4, pat(A + 32'h20));
        load(0, B, 0, 0, pat(B));
        pair(A, B + 32'h10, 4);
        pair(A, B, 0);
        // store hits stay local
        rc = mdl_u.reqCount;
        store(A, D, 16'h00ff, 4, 1);
        store(A, ~D, 16'hff00, 4, 1);
        `CHK("hit no req", rc, mdl_u.reqCount)
        `CHK("hit no wb", 0, wbCnt)
        load(0, A, 0, 4, mrg(mrg(pat(A), D, 16'h00ff), ~D,
            16'hff00));
        // shared line needs ownership; slow partner
        grantExcl = 1'b0;
        delay = 8'h14;
        load(1, C, 0, 0, pat(C));
        grantExcl = 1'b1;
        store(C, D, 16'hffff, 0, 1);
        `CHK("own req", 1'b1, mdl_u.lastOwn)
        `CHK("own line", C[31:6], mdl_u.lastAddr)
        load(0, C, 0, 4, D);
        // fill one set with modified lines, then force a victim
        delay = 8'h00;
        for (int k = 1; k < 9; k++)
            store(k << 12, D, 16'h000f, 0, 1);
        wbCnt = 0;
        load(0, 32'h0000_9000, 0, 0, pat(32'h0000_9000));
        repeat (4) step();
        `CHK("victim beats", 4, wbCnt)
        // tracking depths
        ldAlloc = 1'b1;
        repeat (LDB_ENTRIES - 1) step();
        ldAlloc = 1'b0;
        step();
        step();
        `CHK("ld not full", 1'b0, ldBufFull)
        ldAlloc = 1'b1;
        step();
        ldAlloc = 1'b0;
        step();
        step();
        `CHK("ld full", 1'b1, ldBufFull)
        ldRetire = 1'b1;
        step();
        ldRetire = 1'b0;
        step();
        step();
        `CHK("ld freed", 1'b0, ldBufFull)
        stAlloc = 1'b1;
        repeat (STB_ENTRIES) step();
        stAlloc = 1'b0;
        step();
        step();
        `CHK("st full", 1'b1, stBufFull)
        store(A, D, 16'h0001, 4, 0);
        step();
        `CHK("st freed", 1'b0, stBufFull)
        finish_test();
    end
endmodule
